// >>> design/cts_pkg.sv
// package for the current circuit supervision block
`default_nettype none
package cts_pkg;
  // magnitudes in 0.01 x In units, ratios in 0.01 percent units
  localparam int MAG_W = 16;
  localparam int ANG_W = 16;
  localparam int DLY_W = 19;
  localparam logic [MAG_W-1:0] HIGH_LIMIT_RST = 16'h0078;
  localparam logic [MAG_W-1:0] LOW_LIMIT_RST = 16'h000A;
  localparam logic [MAG_W-1:0] MINMAX_RATIO_RST = 16'h03E8;
  localparam logic [MAG_W-1:0] SEQ_RATIO_RST = 16'h1324;
  localparam logic [MAG_W-1:0] SUM_DIFF_RST = 16'h000A;
  // delay step count: 0.5 s / 5 ms
  localparam logic [DLY_W-1:0] DELAY_STEPS_RST = 19'h00064;
  localparam int DELAY_STEP_US = 5000;
  localparam int CLK_MHZ = 125;
  localparam int STEP_CYCLES = DELAY_STEP_US * CLK_MHZ;
  localparam int HYST_PICK_PCT = 97;
  localparam int HYST_REL_PCT = 103;
  localparam int PCT_DIV = 100;
  localparam int RATIO_SCALE = 10000;

  typedef enum logic [1:0] {RES_NONE, RES_ONE, RES_TWO} residual_sel_t;
  typedef enum logic [1:0] {FORCE_NORMAL, FORCE_ALARM, FORCE_BLOCKED}
    force_sel_t;

  typedef struct packed {
    logic [MAG_W-1:0] phase_a;
    logic [MAG_W-1:0] phase_b;
    logic [MAG_W-1:0] phase_c;
    logic [MAG_W-1:0] residual_channel_one;
    logic [MAG_W-1:0] residual_channel_two;
    logic [MAG_W-1:0] seq_pos;
    logic [MAG_W-1:0] seq_neg;
    logic [MAG_W-1:0] sum_mag_add;
    logic [MAG_W-1:0] sum_mag_sub;
    logic signed [ANG_W-1:0] sum_ang;
    logic signed [ANG_W-1:0] res_ang;
    logic signed [ANG_W-1:0] natural_ang;
  } meas_t;

  typedef struct packed {
    logic [MAG_W-1:0] high_limit;
    logic [MAG_W-1:0] low_limit;
    logic [MAG_W-1:0] minmax_ratio;
    logic [MAG_W-1:0] sequence_unbalance_ratio;
    logic [MAG_W-1:0] sum_diff;
    logic [DLY_W-1:0] delay_steps;
  } settings_t;
endpackage
`default_nettype wire

// >>> design/current_circuit_supervision.sv
// current transformer circuit supervision with definite delay alarm
// Summary of operation
// RL1 - thresholds use 97/103 percent hysteresis
// RL2 - one threshold shared by phases and residual
// RL3 - any phase above upper limit inhibits
// RL4 - lower limit condition on phases required
// RL5 - min/max phase ratio below setting required
// RL6 - negative/positive ratio above setting required
// RL7 - residual difference above limit when enabled
// RL8 - alarm only after definite delay elapses
// RL9 - settings change live without halting
// RL10 - blocking sampled at cycle start
// RL11 - unblocked pick-up asserts start, starts timer
// RL12 - blocked pick-up asserts blocked, no timing
// RL13 - blocking clears start like drop-out
// RL14 - blocker asserts 5 ms before expiry; not implemented here, there is no pre-expiry output
// RL15 - definite-time characteristic only
// RL16 - report residual difference magnitude and angle
// RL17 - report natural unbalance angle
// RL18 - all enabled conditions must hold together
// RL19 - residual selector none, one, two
// RL20 - residual polarity add or subtract
// RL21 - force status normal, alarm, blocked
// RL22 - condition loss clears timer and alarm
`default_nettype none
module current_circuit_supervision #(
  parameter int STEP_CYC = cts_pkg::STEP_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CYCLE_STROBE,
  input wire cts_pkg::meas_t MEAS,
  input wire cts_pkg::settings_t SETTINGS,
  input wire cts_pkg::residual_sel_t RES_SEL,
  input wire logic RES_SUBTRACT,
  input wire logic FORCE_EN,
  input wire cts_pkg::force_sel_t FORCE_SEL,
  input wire logic BLOCK_IN,
  output logic START,
  output logic BLOCKED,
  output logic ALARM,
  output logic [cts_pkg::MAG_W-1:0] SUM_DIFF_MAG,
  output logic signed [cts_pkg::ANG_W-1:0] SUM_DIFF_ANG,
  output logic signed [cts_pkg::ANG_W-1:0] NATURAL_ANG
);
  localparam int SC_W = 24;

  typedef struct packed {
    logic [3:0] above_low;
    logic [2:0] above_high;
    logic ratio_ok;
    logic seq_ok;
    logic diff_ok;
    logic block_s;
    logic start;
    logic blocked;
    logic alarm;
    logic [SC_W-1:0] step_cnt;
    logic [cts_pkg::DLY_W-1:0] steps;
    logic [cts_pkg::MAG_W-1:0] diff_mag;
    logic signed [cts_pkg::ANG_W-1:0] diff_ang;
    logic signed [cts_pkg::ANG_W-1:0] nat_ang;
  } state_t;

  state_t q, d;

  // hysteresis compare: a*100 against thr*103 to pick, thr*97 to hold
  function automatic logic hyst(input logic [cts_pkg::MAG_W-1:0] a,
                                input logic [cts_pkg::MAG_W-1:0] thr,
                                input logic prev);
    logic [31:0] lhs;
    logic [31:0] pick;
    logic [31:0] rel;
    lhs = 32'(a) * 32'(cts_pkg::PCT_DIV);
    pick = 32'(thr) * 32'(cts_pkg::HYST_REL_PCT);
    rel = 32'(thr) * 32'(cts_pkg::HYST_PICK_PCT);
    if (prev) begin
      hyst = lhs > rel; // RL1
    end else begin
      hyst = lhs > pick; // RL1
    end
  endfunction

  function automatic logic [cts_pkg::MAG_W-1:0] mx(
      input logic [cts_pkg::MAG_W-1:0] a,
      input logic [cts_pkg::MAG_W-1:0] b);
    mx = (a > b) ? a : b;
  endfunction

  function automatic logic [cts_pkg::MAG_W-1:0] mn(
      input logic [cts_pkg::MAG_W-1:0] a,
      input logic [cts_pkg::MAG_W-1:0] b);
    mn = (a < b) ? a : b;
  endfunction

  // num*10000*100 > thr*den*pct, hysteresis on the threshold side
  function automatic logic ratio_gt(input logic [cts_pkg::MAG_W-1:0] num,
                                    input logic [cts_pkg::MAG_W-1:0] den,
                                    input logic [cts_pkg::MAG_W-1:0] thr,
                                    input logic prev);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = 48'(num) * 48'(cts_pkg::RATIO_SCALE) * 48'(cts_pkg::PCT_DIV);
    rhs = 48'(thr) * 48'(den);
    if (prev) begin
      ratio_gt = lhs > rhs * 48'(cts_pkg::HYST_PICK_PCT); // RL1
    end else begin
      ratio_gt = lhs > rhs * 48'(cts_pkg::HYST_REL_PCT); // RL1
    end
  endfunction

  logic [cts_pkg::MAG_W-1:0] ph_max, ph_min, res_mag, sum_mag;
  logic res_en, high_any, low_any, low_below, pickup;

  always_comb begin
    ph_max = mx(mx(MEAS.phase_a, MEAS.phase_b), MEAS.phase_c);
    ph_min = mn(mn(MEAS.phase_a, MEAS.phase_b), MEAS.phase_c);
    res_en = (RES_SEL == cts_pkg::RES_ONE) ||
             (RES_SEL == cts_pkg::RES_TWO); // RL19
    res_mag = (RES_SEL == cts_pkg::RES_TWO) ?
              MEAS.residual_channel_two : MEAS.residual_channel_one; // RL19
    // front end supplies both polarities of the phasor sum
    sum_mag = RES_SUBTRACT ? MEAS.sum_mag_sub : MEAS.sum_mag_add; // RL20
    high_any = |q.above_high; // RL3
    low_any = |q.above_low[2:0]; // RL2
    low_below = ~&q.above_low[2:0]; // RL4
    pickup = !high_any && low_any && low_below && q.ratio_ok &&
             q.seq_ok && q.diff_ok; // RL18
  end

  always_comb begin
    d = q;
    if (CYCLE_STROBE) begin
      // settings read live each cycle, no halt on group change
      d.above_low[0] = hyst(MEAS.phase_a, SETTINGS.low_limit,
                            q.above_low[0]); // RL9
      d.above_low[1] = hyst(MEAS.phase_b, SETTINGS.low_limit,
                            q.above_low[1]); // RL2
      d.above_low[2] = hyst(MEAS.phase_c, SETTINGS.low_limit,
                            q.above_low[2]); // RL2
      d.above_low[3] = res_en && hyst(res_mag, SETTINGS.low_limit,
                                      q.above_low[3]); // RL2
      d.above_high[0] = hyst(MEAS.phase_a, SETTINGS.high_limit,
                             q.above_high[0]); // RL3
      d.above_high[1] = hyst(MEAS.phase_b, SETTINGS.high_limit,
                             q.above_high[1]); // RL3
      d.above_high[2] = hyst(MEAS.phase_c, SETTINGS.high_limit,
                             q.above_high[2]); // RL3
      // min/max below setting: inverse of min exceeding it
      d.ratio_ok = !ratio_gt(ph_min, ph_max, SETTINGS.minmax_ratio,
                             !q.ratio_ok) && (ph_max != '0); // RL5
      d.seq_ok = ratio_gt(MEAS.seq_neg, MEAS.seq_pos,
                          SETTINGS.sequence_unbalance_ratio,
                          q.seq_ok) && (MEAS.seq_pos != '0); // RL6
      // residual condition met while monitoring is off, taken at strobe
      d.diff_ok = !res_en ||
                  hyst(sum_mag, SETTINGS.sum_diff, q.diff_ok); // RL7
      d.diff_mag = sum_mag; // RL16
      d.diff_ang = MEAS.sum_ang - MEAS.res_ang; // RL16
      d.nat_ang = MEAS.natural_ang; // RL17
      d.block_s = BLOCK_IN; // RL10
    end
    if (!pickup) begin
      d.start = 1'b0; // RL22
      d.blocked = 1'b0;
      d.alarm = 1'b0; // RL22
      d.steps = '0; // RL22
      d.step_cnt = '0;
    end else if (q.block_s) begin
      d.blocked = 1'b1; // RL12
      d.start = 1'b0; // RL13
      d.alarm = 1'b0; // RL13
      d.steps = '0; // RL13
      d.step_cnt = '0;
    end else begin
      d.start = 1'b1; // RL11
      d.blocked = 1'b0;
      // definite time only: fixed count of 5 ms steps
      if (q.steps >= SETTINGS.delay_steps) begin
        d.alarm = 1'b1; // RL8
      end else if (q.step_cnt == SC_W'(STEP_CYC - 1)) begin
        d.step_cnt = '0;
        d.steps = q.steps + 1'b1; // RL15
      end else begin
        d.step_cnt = q.step_cnt + 1'b1; // RL15
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      q <= '0;
    end else if (CE) begin
      q <= d;
    end
  end

  always_comb begin
    START = q.start;
    BLOCKED = q.blocked;
    ALARM = q.alarm;
    if (FORCE_EN) begin
      case (FORCE_SEL)
        cts_pkg::FORCE_ALARM: begin
          START = 1'b1; // RL21
          BLOCKED = 1'b0;
          ALARM = 1'b1; // RL21
        end
        cts_pkg::FORCE_BLOCKED: begin
          START = 1'b0;
          BLOCKED = 1'b1; // RL21
          ALARM = 1'b0;
        end
        default: begin
          START = 1'b0; // RL21
          BLOCKED = 1'b0;
          ALARM = 1'b0;
        end
      endcase
    end
    SUM_DIFF_MAG = q.diff_mag;
    SUM_DIFF_ANG = q.diff_ang;
    NATURAL_ANG = q.nat_ang;
  end
endmodule
`default_nettype wire

// >>> bench/cts_monitor.sv
// assertion checker for the current circuit supervision block
`default_nettype none
module cts_monitor #(
  parameter int STEP_CYC = 4
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CYCLE_STROBE,
  input wire cts_pkg::settings_t SETTINGS,
  input wire logic FORCE_EN,
  input wire cts_pkg::force_sel_t FORCE_SEL,
  input wire logic START,
  input wire logic BLOCKED,
  input wire logic ALARM
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_q;
  int lim;
  assign lim = int'(SETTINGS.delay_steps) * STEP_CYC;
  // cycles of unforced start held
  always_ff @(posedge MCLK) begin
    if (RST) cnt_q <= 0;
    else if (CE) cnt_q <= (START && !FORCE_EN) ? cnt_q + 1 : 0;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  AST_ALARM_WITH_START: assert property (ALARM |-> START)
    else $error("alarm without start");
  AST_BLOCKED_ALONE: assert property (
    BLOCKED && !FORCE_EN |-> !START && !ALARM)
    else $error("blocked together with start or alarm");
  AST_ALARM_EARLY: assert property (
    ALARM && !FORCE_EN |-> cnt_q >= lim)
    else $error("alarm before delay");
  AST_ALARM_LATE: assert property (
    START && !FORCE_EN && cnt_q >= lim |-> ALARM)
    else $error("alarm missing after delay");
  AST_START_AFTER_STROBE: assert property (
    $rose(START) && !FORCE_EN && !$past(FORCE_EN)
    |-> $past(CYCLE_STROBE, 2))
    else $error("start not tied to a strobe");
  AST_BLOCKED_AFTER_STROBE: assert property (
    $rose(BLOCKED) && !FORCE_EN && !$past(FORCE_EN)
    |-> $past(CYCLE_STROBE, 2))
    else $error("blocked not tied to a strobe");
  AST_FORCE_ALARM: assert property (
    FORCE_EN && FORCE_SEL == cts_pkg::FORCE_ALARM
    |-> ALARM && START && !BLOCKED)
    else $error("forced alarm not shown");
  AST_FORCE_BLOCKED: assert property (
    FORCE_EN && FORCE_SEL == cts_pkg::FORCE_BLOCKED
    |-> BLOCKED && !START && !ALARM)
    else $error("forced block not shown");
  AST_FORCE_NORMAL: assert property (
    FORCE_EN && FORCE_SEL == cts_pkg::FORCE_NORMAL
    |-> !BLOCKED && !START && !ALARM)
    else $error("forced normal not shown");
  cover property ($rose(ALARM) && !FORCE_EN);
  cover property ($rose(BLOCKED) && !FORCE_EN);
  cover property ($fell(START) && !FORCE_EN);
endmodule
bind current_circuit_supervision cts_monitor #(.STEP_CYC(STEP_CYC))
  i_cts_monitor (
  .MCLK(MCLK), .RST(RST), .CE(CE), .CYCLE_STROBE(CYCLE_STROBE),
  .SETTINGS(SETTINGS), .FORCE_EN(FORCE_EN), .FORCE_SEL(FORCE_SEL),
  .START(START), .BLOCKED(BLOCKED), .ALARM(ALARM));
`default_nettype wire

// >>> bench/cts_front_end.sv
// measurement front end and blocking source model
`default_nettype none
module cts_front_end #(
  parameter int PERIOD = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire cts_pkg::meas_t want_meas,
  input wire logic want_block,
  output var logic strobe,
  output var cts_pkg::meas_t meas,
  output var logic block
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_q;
  always_ff @(posedge clk) begin
    cnt_q <= (rst || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
  end
  assign #1 strobe = !rst && cnt_q == PERIOD - 1;
  // off-strobe values are inverted garbage
  assign #1 meas = (cnt_q == PERIOD - 1) ? want_meas
    : ~want_meas;
  assign #1 block = (cnt_q == PERIOD - 1) ? want_block
    : ~want_block;
endmodule
`default_nettype wire

// >>> bench/current_circuit_supervision_tb_top.sv
// testbench for the current circuit supervision block
`default_nettype none
module current_circuit_supervision_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam cts_pkg::meas_t FAULT = '{16'h0064, 16'h0064, 16'h0000,
    16'h0000, 16'h0000, 16'h0064, 16'h0040, 16'h0032, 16'h0000,
    16'h0100, 16'h0040, 16'h0123};
  logic mclk = 0, rst = 1, ce = 1, res_sub = 0, force_en = 0, blk = 0;
  logic strobe, block_in, start, blocked, alarm;
  logic [cts_pkg::MAG_W-1:0] diff_mag;
  logic signed [cts_pkg::ANG_W-1:0] diff_ang, nat_ang;
  cts_pkg::meas_t want = FAULT, meas;
  cts_pkg::settings_t set = '{cts_pkg::HIGH_LIMIT_RST, cts_pkg::LOW_LIMIT_RST,
    cts_pkg::MINMAX_RATIO_RST, cts_pkg::SEQ_RATIO_RST, cts_pkg::SUM_DIFF_RST,
    19'h00003};
  cts_pkg::residual_sel_t sel = cts_pkg::RES_NONE;
  cts_pkg::force_sel_t fsel = cts_pkg::FORCE_NORMAL;
  int failures = 0, compares = 0, cycles = 0;
  cts_front_end i_cts_front_end (.clk(mclk), .rst(rst), .want_meas(want),
    .want_block(blk), .strobe(strobe), .meas(meas), .block(block_in));
  current_circuit_supervision #(.STEP_CYC(4)) i_current_circuit_supervision (
    .MCLK(mclk), .RST(rst), .CE(ce), .CYCLE_STROBE(strobe), .MEAS(meas),
    .SETTINGS(set), .RES_SEL(sel), .RES_SUBTRACT(res_sub),
    .FORCE_EN(force_en), .FORCE_SEL(fsel), .BLOCK_IN(block_in),
    .START(start), .BLOCKED(blocked), .ALARM(alarm), .SUM_DIFF_MAG(diff_mag),
    .SUM_DIFF_ANG(diff_ang), .NATURAL_ANG(nat_ang));
  initial forever #4 mclk = ~mclk;
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic outs(input logic s, input logic b, input logic a);
    check(16'(start), 16'(s));
    check(16'(blocked), 16'(b));
    check(16'(alarm), 16'(a));
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    want.phase_c = 16'h0064;
    want.seq_neg = 16'h0000;
    step(10);
    rst = 0;
    step(12);
    outs(0, 0, 0);
    want = FAULT;
    repeat (20) if (!start) step(1);
    outs(1, 0, 0);
    step(10);
    check(16'(alarm), 16'h0000);
    step(4);
    check(16'(alarm), 16'h0001);
    check(nat_ang, 16'h0123);
    $display("test delay done");
    blk = 1;
    step(12);
    outs(0, 1, 0);
    blk = 0;
    step(12);
    outs(1, 0, 0);
    set.low_limit = 16'h00C8;
    step(12);
    outs(0, 0, 0);
    set.low_limit = cts_pkg::LOW_LIMIT_RST;
    want.phase_a = 16'h00C8;
    step(12);
    outs(0, 0, 0);
    want = FAULT;
    want.phase_a = 16'h0032;
    want.phase_b = 16'h0032;
    want.phase_c = 16'h0009;
    step(12);
    outs(0, 0, 0);
    want = FAULT;
    want.seq_neg = 16'h002E;
    step(12);
    outs(0, 0, 0);
    want = FAULT;
    $display("test block and limits done");
    for (int i = 1; i < 3; i++) begin
      sel = cts_pkg::residual_sel_t'(i);
      step(12);
      check(16'(start), 16'h0001);
    end
    check(diff_mag, 16'h0032);
    check(diff_ang, 16'h00C0);
    res_sub = 1;
    step(12);
    check(16'(start), 16'h0000);
    check(diff_mag, 16'h0000);
    sel = cts_pkg::RES_NONE;
    step(12);
    check(16'(start), 16'h0001);
    res_sub = 0;
    $display("test residual done");
    want.phase_a = 16'h000B;
    want.phase_b = 16'h000B;
    step(12);
    check(16'(start), 16'h0001);
    want.phase_a = 16'h000A;
    want.phase_b = 16'h000A;
    step(12);
    check(16'(start), 16'h0001);
    want.phase_a = 16'h0009;
    want.phase_b = 16'h0009;
    step(12);
    outs(0, 0, 0);
    $display("test hysteresis done");
    want = FAULT;
    ce = 0;
    step(12);
    outs(0, 0, 0);
    ce = 1;
    step(12);
    check(16'(start), 16'h0001);
    $display("test enable done");
    force_en = 1;
    for (int f = 0; f < 3; f++) begin
      fsel = cts_pkg::force_sel_t'(f);
      step(1);
      outs(f == 1, f == 2, f == 1);
    end
    force_en = 0;
    $display("test force done");
    give_verdict();
  end
endmodule
`default_nettype wire
